// file: move_and_multiply_exec.sv
// execution datapath for move, bank load and unsigned multiply instructions
`timescale 1ns/1ps
`default_nettype none
module move_and_multiply_exec (
	input wire logic ref_clk_in, // core clock
	input wire logic reset_in, // synchronous reset, active high
	input wire logic start_in, // one-cycle pulse: instruction word valid
	input wire logic [15:0] instr_in, // instruction word
	input wire logic ext_set_in, // extended instruction set enabled
	input wire logic [7:0] mem_rdata_in, // data memory read data
	output logic busy_out, // instruction cycle in progress
	output logic done_out, // pulse when destination written
	output logic illegal_out, // pulse: word not handled here
	output logic [7:0] accumulator_out, // accumulator
	output logic [7:0] bank_select_register_out, // bank select register
	output logic [7:0] product_high_out, // product high byte
	output logic [7:0] product_low_out, // product low byte
	output logic [11:0] mem_addr_out, // data memory address
	output logic mem_rd_out, // data memory read strobe
	output logic mem_wr_out, // data memory write strobe
	output logic [7:0] mem_wdata_out, // data memory write data
	output logic indexed_out // pulse: indexed literal offset needed
);
	import exec_pkg::*;

	phase_t phase_q;
	op_kind_t kind_q;
	logic [15:0] instr_q;
	logic [7:0] operand_q;
	logic [15:0] product_q;
	logic [7:0] acc_q, bsr_q;
	logic [7:0] prod_h_q, prod_l_q;
	logic [11:0] addr_q;
	logic rd_q, wr_q, done_q, illegal_q, indexed_q, idx_hold_q;
	logic [7:0] wdata_q;
	logic busy_q, take_d;
	op_kind_t kind_d;
	mem_port_if mp();

	// classify an instruction word
	function automatic op_kind_t decode(input logic [15:0] w);
		op_kind_t k;
		k = OPK_NONE;
		if (w[OPC_HI:OPC_LO] == OP_BANK_SELECT_LOAD) begin
			k = OPK_BANK_LOAD;
		end else if (w[OPC_HI:OPC_LO] == OP_LOAD_LITERAL) begin
			k = OPK_LIT_LOAD;
		end else if (w[OPC_HI:OPC_LO] == OP_MULTIPLY_LITERAL) begin
			k = OPK_MUL_LIT;
		end else if (w[OPC_HI:ACCESS_BIT+1] == OP_STORE_ACCUMULATOR) begin
			k = OPK_STORE;
		end else if (w[OPC_HI:ACCESS_BIT+1] == OP_MULTIPLY_FILE) begin
			k = OPK_MUL_FILE;
		end
		return k;
	endfunction

	// unsigned 8x8 multiply; 16 bits always hold the product
	function automatic logic [15:0] umul(input logic [7:0] a,
		input logic [7:0] b);
		return {8'h00, a} * {8'h00, b};
	endfunction

	// acceptance of a word: only while idle; the latch block decodes the word a second time
	always_comb begin
		take_d = (phase_q == PH_IDLE) && start_in;
		kind_d = decode(instr_in);
	end

	// file and access fields taken from the latched word, extended-set enable and bank taken live
	assign mp.file = instr_q[7:0];
	assign mp.access = instr_q[ACCESS_BIT];
	assign mp.ext_en = ext_set_in;
	assign mp.bank = bsr_q;

	// bank or access bank address former
	addr_former u_addr (
		.mp(mp)
	);

	// four-phase sequencer: decode, read, process, write
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			phase_q <= PH_IDLE;
		end else begin
			case (phase_q)
				PH_IDLE: if (take_d && kind_d != OPK_NONE)
					phase_q <= PH_READ;
				PH_READ: phase_q <= PH_PROCESS;
				PH_PROCESS: phase_q <= PH_WRITE;
				PH_WRITE: phase_q <= PH_IDLE;
				default: phase_q <= PH_IDLE;
			endcase
		end
	end

	// latch the instruction at decode
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			instr_q <= 16'h0000;
			kind_q <= OPK_NONE;
		end else if (phase_q == PH_IDLE && start_in) begin
			instr_q <= instr_in;
			kind_q <= decode(instr_in);
		end
	end

	// operand read phase: literal or memory byte
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			operand_q <= 8'h00;
			addr_q <= 12'h000;
			rd_q <= 1'b0;
			idx_hold_q <= 1'b0;
		end else begin
			rd_q <= 1'b0;
			if (phase_q == PH_READ) begin
				operand_q <= instr_q[7:0];
				if (kind_q == OPK_MUL_FILE || kind_q == OPK_STORE) begin
					addr_q <= mp.addr;
					idx_hold_q <= mp.indexed;
					rd_q <= (kind_q == OPK_MUL_FILE);
				end else begin
					idx_hold_q <= 1'b0;
				end
			end else if (phase_q == PH_PROCESS && kind_q == OPK_MUL_FILE) begin
				operand_q <= mem_rdata_in;
			end
		end
	end

	// process phase: form the product
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			product_q <= PROD_RESET;
		end else if (phase_q == PH_PROCESS) begin
			if (kind_q == OPK_MUL_FILE) begin
				product_q <= umul(acc_q, mem_rdata_in);
			end else begin
				product_q <= umul(acc_q, operand_q);
			end
		end
	end

	// write phase: accumulator and bank select register
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			acc_q <= ACC_RESET;
			bsr_q <= BSR_RESET;
		end else if (phase_q == PH_WRITE) begin
			if (kind_q == OPK_LIT_LOAD) begin
				acc_q <= operand_q;
			end
			if (kind_q == OPK_BANK_LOAD) begin
				bsr_q <= {4'h0, operand_q[NIBBLE_HI:0]};
			end
		end
	end

	// write phase: product pair, accumulator untouched by multiplies
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			prod_h_q <= PROD_RESET[15:8];
			prod_l_q <= PROD_RESET[7:0];
		end else if (phase_q == PH_WRITE &&
			(kind_q == OPK_MUL_LIT || kind_q == OPK_MUL_FILE)) begin
			prod_h_q <= product_q[15:8];
			prod_l_q <= product_q[7:0];
		end
	end

	// memory write strobe for the store, no flag logic in this block
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			wr_q <= 1'b0;
			wdata_q <= 8'h00;
		end else begin
			wr_q <= (phase_q == PH_PROCESS && kind_q == OPK_STORE);
			if (phase_q == PH_PROCESS) begin
				wdata_q <= acc_q;
			end
		end
	end

	// completion, indexed and illegal pulses
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			done_q <= 1'b0;
			illegal_q <= 1'b0;
			indexed_q <= 1'b0;
		end else begin
			done_q <= (phase_q == PH_WRITE);
			illegal_q <= take_d && kind_d == OPK_NONE;
			indexed_q <= (phase_q == PH_PROCESS) && idx_hold_q;
		end
	end

	// busy flag: set when a handled word is taken, cleared with the write phase
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			busy_q <= 1'b0;
		end else if (take_d && kind_d != OPK_NONE) begin
			busy_q <= 1'b1;
		end else if (phase_q == PH_WRITE) begin
			busy_q <= 1'b0;
		end
	end

	// every output comes straight from its register
	assign busy_out = busy_q;
	assign done_out = done_q;
	assign illegal_out = illegal_q;
	assign accumulator_out = acc_q;
	assign bank_select_register_out = bsr_q;
	assign product_high_out = prod_h_q;
	assign product_low_out = prod_l_q;
	assign mem_addr_out = addr_q;
	assign mem_rd_out = rd_q;
	assign mem_wr_out = wr_q;
	assign mem_wdata_out = wdata_q;
	assign indexed_out = indexed_q;
endmodule
`default_nettype wire

// file: exec_pkg.sv
// constants and types shared by the move and multiply execution datapath
package exec_pkg;
	localparam logic [7:0] OP_BANK_SELECT_LOAD = 8'h01;
	localparam logic [7:0] OP_LOAD_LITERAL = 8'h0E;
	localparam logic [7:0] OP_MULTIPLY_LITERAL = 8'h0D;
	localparam logic [6:0] OP_STORE_ACCUMULATOR = 7'h37;
	localparam logic [6:0] OP_MULTIPLY_FILE = 7'h01;
	localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
	localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
	localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
	localparam logic [7:0] ACCESS_SPLIT = 8'h60;
	localparam logic [7:0] BSR_RESET = 8'h00;
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [15:0] PROD_RESET = 16'h0000;
	localparam int OPC_HI = 15;
	localparam int OPC_LO = 8;
	localparam int ACCESS_BIT = 8;
	localparam int NIBBLE_HI = 3;
	typedef enum logic [2:0] {
		OPK_NONE,
		OPK_BANK_LOAD,
		OPK_LIT_LOAD,
		OPK_STORE,
		OPK_MUL_LIT,
		OPK_MUL_FILE
	} op_kind_t;
	typedef enum {PH_IDLE, PH_READ, PH_PROCESS, PH_WRITE} phase_t;
endpackage

// file: mem_port_if.sv
// data memory request signals between decoder and address former
`timescale 1ns/1ps
`default_nettype none
interface mem_port_if;
	logic [7:0] file;
	logic access;
	logic ext_en;
	logic [7:0] bank;
	logic [11:0] addr;
	logic indexed;
	modport requester(output file, access, ext_en, bank,
		input addr, indexed);
	modport former(input file, access, ext_en, bank,
		output addr, indexed);
endinterface
`default_nettype wire

// file: addr_former.sv
// forms the 12-bit data address from file field, access bit and bank
`timescale 1ns/1ps
`default_nettype none
module addr_former (
	mem_port_if.former mp // address request and result
);
	import exec_pkg::*;
	// bank or access bank selection
	always_comb begin
		mp.indexed = 1'b0;
		if (mp.access) begin
			mp.addr = {mp.bank[NIBBLE_HI:0], mp.file};
		end else begin
			if (mp.file < ACCESS_SPLIT) begin
				mp.addr = {ACCESS_LOW_BANK, mp.file};
			end else begin
				mp.addr = {ACCESS_HIGH_BANK, mp.file};
			end
			mp.indexed = mp.ext_en && (mp.file <= INDEXED_LIMIT);
		end
	end
endmodule
`default_nettype wire

// file: mm_exec_chk.sv
// assertion checker for the move and multiply datapath
`timescale 1ns/1ps
`default_nettype none
module mm_exec_chk (
	input wire logic ref_clk_in, // clock
	input wire logic reset_in, // reset
	input wire logic start_in, // start
	input wire logic [15:0] instr_in, // word
	input wire logic ext_set_in, // extended set
	input wire logic [7:0] mem_rdata_in, // read data
	input wire logic busy_out, // busy
	input wire logic done_out, // done
	input wire logic [7:0] accumulator_out, // acc
	input wire logic [7:0] bank_select_register_out, // bank
	input wire logic [7:0] product_high_out, // high
	input wire logic [7:0] product_low_out, // low
	input wire logic [11:0] mem_addr_out, // address
	input wire logic mem_rd_out, // read
	input wire logic mem_wr_out, // write
	input wire logic [7:0] mem_wdata_out, // write data
	input wire logic indexed_out // indexed
);
	logic tk;
	logic [7:0] op;
	logic [15:0] pr;
	// taken request, its opcode and the product pair
	assign tk = start_in && !busy_out;
	assign op = instr_in[15:8];
	assign pr = {product_high_out, product_low_out};
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);
	AST_DONE: assert property (done_out |-> $past(tk, 4))
		else $error("done without a taken start");
	AST_BUSY: assert property ($rose(busy_out) |->
		busy_out [*3] ##1 (done_out && !busy_out))
		else $error("busy length wrong");
	AST_BSR: assert property (bank_select_register_out[7:4] == 4'h0)
		else $error("bank high nibble set");
	AST_BANK: assert property (done_out && $past(tk && op == 8'h01, 4) |->
		bank_select_register_out == {4'h0, $past(instr_in[3:0], 4)})
		else $error("bank load wrong");
	AST_LIT: assert property (done_out && $past(tk && op == 8'h0E, 4) |->
		accumulator_out == $past(instr_in[7:0], 4))
		else $error("literal load wrong");
	AST_MULL: assert property (done_out && $past(tk && op == 8'h0D, 4) |->
		pr == $past(accumulator_out, 4) * $past(instr_in[7:0], 4)
		&& accumulator_out == $past(accumulator_out, 4))
		else $error("literal product wrong");
	AST_MULF: assert property (done_out
		&& $past(tk && instr_in[15:9] == 7'h01, 4) |->
		pr == $past(accumulator_out, 4) * $past(mem_rdata_in, 2))
		else $error("file product wrong");
	AST_WR: assert property (mem_wr_out |-> mem_wdata_out == accumulator_out
		&& $past(tk && instr_in[15:9] == 7'h37, 3))
		else $error("stray or wrong write");
	AST_ADDR: assert property (mem_rd_out && $past(instr_in[8], 2) |->
		mem_addr_out == {bank_select_register_out[3:0], $past(instr_in[7:0], 2)})
		else $error("banked address wrong");
	AST_IDX: assert property (indexed_out |-> $past(tk && !instr_in[8]
		&& ext_set_in && instr_in[7:0] <= 8'h5F, 3))
		else $error("stray indexed flag");
endmodule
bind move_and_multiply_exec mm_exec_chk chk_u (.ref_clk_in, .reset_in,
	.start_in, .instr_in, .ext_set_in, .mem_rdata_in, .busy_out, .done_out,
	.accumulator_out, .bank_select_register_out, .product_high_out,
	.product_low_out, .mem_addr_out, .mem_rd_out, .mem_wr_out,
	.mem_wdata_out, .indexed_out);
`default_nettype wire

// file: test_move_and_multiply_exec.sv
// self-checking bench for the move and multiply datapath
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
	num_errors++; $display("unexpected at %0t: got %h", $time, a); end end
module test_move_and_multiply_exec;
	logic ref_clk_in = 0, reset_in = 1, start_in = 0, ext_set_in = 0;
	logic [15:0] instr_in = 16'h0000;
	logic [7:0] mem_rdata_in = 8'h00;
	logic busy, done_out, ill_p, rd_p, wr_p, idx_p, rd, wr, idx, ill, bsy;
	logic [7:0] acc, bank_select_register, ph, pl, wdata, wd;
	logic [11:0] mem_addr, addr;
	int num_errors = 0, check_count = 0, cyc = 0, lat = 0;
	always #4 ref_clk_in = ~ref_clk_in;
	move_and_multiply_exec dut_u (.ref_clk_in, .reset_in, .start_in,
		.instr_in, .ext_set_in, .mem_rdata_in, .busy_out(busy), .done_out,
		.illegal_out(ill_p), .accumulator_out(acc),
		.bank_select_register_out(bank_select_register), .product_high_out(ph),
		.product_low_out(pl), .mem_addr_out(mem_addr), .mem_rd_out(rd_p),
		.mem_wr_out(wr_p), .mem_wdata_out(wdata), .indexed_out(idx_p));
	// verdict and end of run
	task automatic end_sim();
		if (num_errors == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// issues one word, records pulses until done
	task automatic issue(input logic [15:0] w);
		int n;
		@(negedge ref_clk_in);
		instr_in = w;
		start_in = 1'b1;
		@(negedge ref_clk_in);
		start_in = 1'b0;
		{rd, wr, idx, ill, bsy} = 5'h00;
		for (n = 0; n < 6 && done_out !== 1'b1; n++) begin
			rd = rd | rd_p;
			wr = wr | wr_p;
			idx = idx | idx_p;
			ill = ill | ill_p;
			bsy = bsy | busy;
			if (rd_p | wr_p)
				addr = mem_addr;
			if (wr_p)
				wd = wdata;
			@(negedge ref_clk_in);
		end
		lat = n;
	endtask
	// literal and bank loads
	task automatic t_loads();
		issue(16'h0EA5);
		`CHK(acc, 8'hA5)
		`CHK(done_out, 1'b1)
		`CHK(lat, 32'h3)
		`CHK({bsy, busy}, 2'b10)
		issue(16'h01F7);
		`CHK(bank_select_register, 8'h07)
	endtask
	// literal multiply, nonzero and zero product
	task automatic t_mul_lit();
		issue(16'h0EE2);
		issue(16'h0DC4);
		`CHK({ph, pl}, 16'hAD08)
		`CHK(acc, 8'hE2)
		issue(16'h0D00);
		`CHK({ph, pl}, 16'h0000)
	endtask
	// file multiply through the bank register
	task automatic t_mul_file();
		mem_rdata_in = 8'hB5;
		issue(16'h0EC4);
		issue(16'h0333);
		`CHK({rd, wr}, 2'b10)
		`CHK(addr, 12'h733)
		`CHK({ph, pl}, 16'h8A94)
		`CHK(acc, 8'hC4)
	endtask
	// stores through access bank, indexed limit and bank
	task automatic t_store();
		ext_set_in = 1'b1;
		issue(16'h6E70);
		`CHK({wr, idx, addr}, {2'b10, 12'hF70})
		`CHK(wd, 8'hC4)
		issue(16'h6E5F);
		`CHK({idx, addr}, {1'b1, 12'h05F})
		ext_set_in = 1'b0;
		issue(16'h6F5F);
		`CHK({idx, addr}, {1'b0, 12'h75F})
	endtask
	// word of no handled kind
	task automatic t_illegal();
		issue(16'hFFFF);
		`CHK(ill, 1'b1)
		`CHK(bsy, 1'b0)
		`CHK(acc, 8'hC4)
	endtask
	// a start given while busy is ignored
	task automatic t_refused();
		@(negedge ref_clk_in);
		instr_in = 16'h0E11;
		start_in = 1'b1;
		@(negedge ref_clk_in);
		instr_in = 16'h0E22;
		@(negedge ref_clk_in);
		start_in = 1'b0;
		repeat (4) @(negedge ref_clk_in);
		`CHK(acc, 8'h11)
		`CHK(busy, 1'b0)
	endtask
	// bounded run length
	always @(posedge ref_clk_in) begin
		cyc++;
		if (cyc == 2000) begin
			num_errors++;
			end_sim();
		end
	end
	// reset then scenarios
	initial begin
		repeat (6) @(negedge ref_clk_in);
		reset_in = 1'b0;
		t_loads();
		t_mul_lit();
		t_mul_file();
		t_store();
		t_illegal();
		t_refused();
		end_sim();
	end
endmodule
`default_nettype wire
